// >>> acq_defs.vh
// constants for the acquisition mode control register
`ifndef ACQ_DEFS_VH
`define ACQ_DEFS_VH
`define ACQ_MODE_OFFSET      8'h0F
`define ACQ_MODE_RESET       8'h00
`define ACQ_BIT_RCV_DISABLE  4
`define ACQ_BIT_TWO_WIRE     3
`define ACQ_BIT_CONV_DRIVE   2
`define ACQ_BIT_IVL_RECEIVE  1
`define ACQ_BIT_IVL_SCAN     0
`define ACQ_IN_GROUND_REF    2'h0
`define ACQ_IN_COMMON_SENSE  2'h1
`define ACQ_IN_TWO_WIRE      2'h2
`define ACQ_CONV_PULSE_NS    100
// ten cycles of the 10 ns clock cover the pulse length above
`define ACQ_CONV_PULSE_CYC   4'hA
`endif

// >>> acq_mode_control.v
// acquisition mode control register with pin steering and clock selection
`timescale 1ns/1ps
`include "acq_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - With receive-disable set, external convert pin activity is ignored.
// - With receive-disable and convert drive clear, each falling edge on the convert pin starts one conversion.
// - Input mode is ground-referenced, common-sense or two-wire from the select bit and partner bit.
// - The convert drive bit resets to zero, leaving the convert pin an input.
// - With convert drive set, conversions are internally timed and pulsed out on the convert pin.
// - With interval receive clear, the second B counter clocks scanning and the interval pin is an output.
// - With interval receive set, the interval pin is an input that clocks scanning.
// - Interval scan bit one selects interval acquisition, zero continuous.
// - With interval scan zero, the interval counter clock comes from its connector pin.
// - With interval scan one, the interval counter shares the sample-interval counter clock.
// - Time-base select clear gives 1 MHz to the sample counter, set gives first B counter output.
module acq_mode_control (
   input  wire       i_clk,               // 100 MHz clock
   input  wire       i_reset_n,           // async reset, active low
   input  wire       i_ce,                // clock enable, freezes state when low
   input  wire       i_wr,                // host write strobe
   input  wire [7:0] i_addr,              // host register address
   input  wire [7:0] i_wdata,             // host write data
   input  wire       i_ref_floating,      // partner input mode bit from other register
   input  wire       i_time_base_select,  // time-base select bit from other register
   input  wire       i_tick_1mhz,         // 1 MHz time-base enable pulse
   input  wire       i_first_b_out,       // first B counter output level
   input  wire       i_second_b_out,      // second B counter output level
   input  wire       i_sample_tick,       // internal sample timer conversion request
   input  wire       i_conv_pin_in,       // external convert pin level, active low
   input  wire       i_ivl_pin_in,        // interval clock pin level
   input  wire       i_ivl_ctr_clk_pin,   // interval counter clock from connector
   output reg        o_conv_start,        // one-cycle conversion start
   output reg  [1:0] o_input_mode,        // decoded analog input mode
   output reg        o_conv_pin_out_n,    // convert pin drive level, active low
   output reg        o_conv_pin_oe,       // convert pin output enable
   output reg        o_ivl_pin_out,       // interval clock pin drive level
   output reg        o_ivl_pin_oe,        // interval clock pin output enable
   output reg        o_scan_clk,          // interval scan circuitry clock level
   output reg        o_interval_mode,     // one: interval acquisition, zero: continuous
   output reg        o_sample_ctr_clk,    // sample-interval counter clock source
   output reg        o_ivl_ctr_clk        // interval counter clock source
);

   localparam [7:0] MODE_RESET = `ACQ_MODE_RESET;
   localparam [3:0] PULSE_LEN  = `ACQ_CONV_PULSE_CYC;
   // one-hot states of the outgoing convert pulse
   localparam [1:0] PULSE_IDLE = 2'b01;
   localparam [1:0] PULSE_LOW  = 2'b10;

   reg  [7:0] mode_q;
   reg        conv_pin_q;
   reg  [3:0] pulse_cnt_q;
   reg  [3:0] pulse_cnt_d;
   reg  [1:0] pulse_state_q;
   reg  [1:0] pulse_state_d;
   reg  [1:0] input_mode_d;
   reg        base_clk;
   reg        ivl_pin_oe_d;
   reg        ivl_pin_out_d;
   reg        scan_clk_d;
   reg        interval_mode_d;
   reg        sample_ctr_clk_d;
   reg        ivl_ctr_clk_d;
   wire       wr_hit;
   wire       rcv_disable;
   wire       two_wire;
   wire       conv_drive;
   wire       ivl_receive;
   wire       ivl_scan;
   wire       ext_fall;
   wire       start_d;
   wire       conv_low_d;
   genvar     gi;

   ////////////////////////////////////////////////////////////////////////////
   // register write; no read path, other addresses pass silently
   assign wr_hit = i_ce & i_wr & (i_addr == `ACQ_MODE_OFFSET);

   // top bits kept as written, software keeps them zero
   // one flop per bit, all on the same write enable
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_mode_bit
         always @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               mode_q[gi] <= MODE_RESET[gi];
            end else if (wr_hit) begin
               mode_q[gi] <= i_wdata[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // field taps
   assign rcv_disable = mode_q[`ACQ_BIT_RCV_DISABLE];
   assign two_wire    = mode_q[`ACQ_BIT_TWO_WIRE];
   assign conv_drive  = mode_q[`ACQ_BIT_CONV_DRIVE];
   assign ivl_receive = mode_q[`ACQ_BIT_IVL_RECEIVE];
   assign ivl_scan    = mode_q[`ACQ_BIT_IVL_SCAN];

   ////////////////////////////////////////////////////////////////////////////
   // convert pin edge detection and internally timed start
   assign ext_fall   = conv_pin_q & ~i_conv_pin_in;
   // pin is an input only while not driven; drive mode times internally
   assign start_d    = conv_drive ? i_sample_tick
                                  : (ext_fall & ~rcv_disable);
   // pulse made visible long enough for external channels to see it
   assign conv_low_d = conv_drive & (i_sample_tick |
                       ((pulse_state_q == PULSE_LOW) & (pulse_cnt_q > 4'h1)));

   // idle level after reset, so no false edge follows reset
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         conv_pin_q <= 1'b1;
      end else if (i_ce) begin
         conv_pin_q <= i_conv_pin_in;
      end
   end

   // one cycle wide start towards the converter
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_conv_start <= 1'b0;
      end else if (i_ce) begin
         o_conv_start <= start_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outgoing pulse length counter and its state
   always @* begin
      pulse_cnt_d = pulse_cnt_q;
      if (conv_drive && i_sample_tick) begin
         pulse_cnt_d = PULSE_LEN;
      end else if (pulse_cnt_q != 4'h0) begin
         pulse_cnt_d = pulse_cnt_q - 4'h1;
      end
   end

   // leaving drive mode drops the pulse at once, the pin turns to input
   always @* begin
      pulse_state_d = pulse_state_q;
      case (pulse_state_q)
         PULSE_IDLE: begin
            if (conv_drive && i_sample_tick) begin
               pulse_state_d = PULSE_LOW;
            end
         end
         PULSE_LOW: begin
            if (!conv_drive) begin
               pulse_state_d = PULSE_IDLE;
            end else if (!i_sample_tick && pulse_cnt_q <= 4'h1) begin
               pulse_state_d = PULSE_IDLE;
            end
         end
         default: begin
            pulse_state_d = PULSE_IDLE;
         end
      endcase
   end

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pulse_cnt_q <= 4'h0;
      end else if (i_ce) begin
         pulse_cnt_q <= pulse_cnt_d;
      end
   end

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pulse_state_q <= PULSE_IDLE;
      end else if (i_ce) begin
         pulse_state_q <= pulse_state_d;
      end
   end

   // convert pin drive level, high while idle
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_conv_pin_out_n <= 1'b1;
      end else if (i_ce) begin
         o_conv_pin_out_n <= ~conv_low_d;
      end
   end

   // convert pin drives only in drive mode
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_conv_pin_oe <= 1'b0;
      end else if (i_ce) begin
         o_conv_pin_oe <= conv_drive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input mode decode; two-wire wins over the partner bit
   always @* begin
      case ({two_wire, i_ref_floating})
         2'b00: begin
            input_mode_d = `ACQ_IN_GROUND_REF;
         end
         2'b01: begin
            input_mode_d = `ACQ_IN_COMMON_SENSE;
         end
         default: begin
            input_mode_d = `ACQ_IN_TWO_WIRE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock steering; every selection is registered, so each lags one cycle
   always @* begin
      if (i_time_base_select) begin
         base_clk = i_first_b_out;
      end else begin
         base_clk = i_tick_1mhz;
      end
   end

   always @* begin
      ivl_pin_oe_d     = ~ivl_receive;
      ivl_pin_out_d    = i_second_b_out;
      scan_clk_d       = ivl_receive ? i_ivl_pin_in : i_second_b_out;
      interval_mode_d  = ivl_scan;
      sample_ctr_clk_d = base_clk;
      ivl_ctr_clk_d    = ivl_scan ? base_clk : i_ivl_ctr_clk_pin;
   end

   ////////////////////////////////////////////////////////////////////////////
   // output flops
   // analog input mode
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_input_mode <= `ACQ_IN_GROUND_REF;
      end else if (i_ce) begin
         o_input_mode <= input_mode_d;
      end
   end

   // interval pin is an output out of reset
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ivl_pin_oe <= 1'b1;
      end else if (i_ce) begin
         o_ivl_pin_oe <= ivl_pin_oe_d;
      end
   end

   // interval pin drive level
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ivl_pin_out <= 1'b0;
      end else if (i_ce) begin
         o_ivl_pin_out <= ivl_pin_out_d;
      end
   end

   // interval scan clock
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_scan_clk <= 1'b0;
      end else if (i_ce) begin
         o_scan_clk <= scan_clk_d;
      end
   end

   // interval or continuous acquisition
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_interval_mode <= 1'b0;
      end else if (i_ce) begin
         o_interval_mode <= interval_mode_d;
      end
   end

   // sample-interval counter clock
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_sample_ctr_clk <= 1'b0;
      end else if (i_ce) begin
         o_sample_ctr_clk <= sample_ctr_clk_d;
      end
   end

   // interval counter clock; free for user work while scanning is off
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ivl_ctr_clk <= 1'b0;
      end else if (i_ce) begin
         o_ivl_ctr_clk <= ivl_ctr_clk_d;
      end
   end

endmodule

// >>> acq_far_side.sv
// far-side model: connector convert pin and clock sources
`timescale 1ns/1ps
module acq_far_side (
   input  wire       i_clk,            // system clock
   input  wire       i_fire,           // hold the convert pin low
   output reg        o_conv_n = 1'b1,  // convert pin level, active low
   output wire [4:0] o_clk             // free-running clock sources
);
   reg [4:0] cnt_q = 5'h00;
   // counter bits stand in for time base, counters and pins
   assign o_clk = cnt_q;
   always @(posedge i_clk) begin
      cnt_q <= cnt_q + 5'h01;
      o_conv_n <= #1 ~i_fire;  // one falling edge per request
   end
endmodule

// >>> acq_mode_checker.sv
// assertions for the acquisition mode control register
`timescale 1ns/1ps
module acq_mode_checker (
   input wire       i_clk, i_reset_n, i_ce, i_wr, i_ref_floating, i_time_base_select, i_tick_1mhz,
   input wire       i_first_b_out, i_second_b_out, i_sample_tick, i_conv_pin_in, i_ivl_pin_in,
   input wire       i_ivl_ctr_clk_pin, o_conv_start, o_conv_pin_out_n, o_conv_pin_oe, o_ivl_pin_oe,
   input wire       o_scan_clk, o_interval_mode, o_sample_ctr_clk, o_ivl_ctr_clk, o_ivl_pin_out,
   input wire [7:0] i_addr, i_wdata,
   input wire [1:0] o_input_mode
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_write_latch: assert property (i_wr && i_ce && i_addr == 8'h0F |-> ##2
      {o_input_mode[1], o_conv_pin_oe, !o_ivl_pin_oe, o_interval_mode} == $past(i_wdata[3:0], 2)) else $error("no latch");
   a_start_cause: assert property (o_conv_start |->
      $past(i_sample_tick) || $past(i_conv_pin_in, 2) && !$past(i_conv_pin_in)) else $error("stray start");
   a_drive_pulse: assert property (i_sample_tick && o_conv_pin_oe && $past(o_conv_pin_oe) |=>
      o_conv_start && !o_conv_pin_out_n) else $error("no drive pulse");
   a_pulse_width: assert property ($fell(o_conv_pin_out_n) |-> (!o_conv_pin_out_n) [*8]) else $error("short pulse");
   a_mode_decode: assert property ($past(i_reset_n) && o_input_mode != 2'h2 |->
      o_input_mode == {1'b0, $past(i_ref_floating)}) else $error("bad input mode");
   a_scan_source: assert property ($past(i_reset_n) |->
      o_scan_clk == (o_ivl_pin_oe ? $past(i_second_b_out) : $past(i_ivl_pin_in))) else $error("bad scan clock");
   a_ctr_source: assert property ($past(i_reset_n) |->
      o_ivl_ctr_clk == (o_interval_mode ? o_sample_ctr_clk : $past(i_ivl_ctr_clk_pin))) else $error("bad ctr clock");
   a_ivl_drive: assert property ($past(i_reset_n) |->
      o_ivl_pin_out == $past(i_second_b_out)) else $error("bad interval drive");
   a_time_base: assert property ($past(i_reset_n) |-> o_sample_ctr_clk ==
      ($past(i_time_base_select) ? $past(i_first_b_out) : $past(i_tick_1mhz))) else $error("bad time base");
endmodule
bind acq_mode_control acq_mode_checker acq_mode_checker_i (.*);

// >>> testbench.sv
// self-checking bench for the acquisition mode control register
`timescale 1ns/1ps
module testbench;
   reg        i_clk = 0, rst_n = 0, wr = 0, ref_f = 0, tbs = 0, st = 0, fire = 0;
   reg  [7:0] addr = 8'h00, wd = 8'h00;
   wire [1:0] mode;
   wire [4:0] k;
   wire       cs, cn, coe, io, ioe, im, fc;
   integer    bad_count = 0, n_checks = 0, starts = 0, lows = 0, cyc = 0, s0, l0, i;
   // pin levels resolved from the controller's enables; the far side drives them otherwise
   wire       conv_w = coe ? cn : fc;
   wire       ivl_w = ioe ? io : k[3];
   acq_mode_control acq_mode_control_i (.i_clk(i_clk), .i_reset_n(rst_n), .i_ce(1'b1), .i_wr(wr), .i_addr(addr),
      .i_wdata(wd), .i_ref_floating(ref_f), .i_time_base_select(tbs), .i_tick_1mhz(k[0]), .i_first_b_out(k[1]),
      .i_second_b_out(k[2]), .i_sample_tick(st), .i_conv_pin_in(conv_w), .i_ivl_pin_in(ivl_w), .i_ivl_ctr_clk_pin(k[4]),
      .o_conv_start(cs), .o_input_mode(mode), .o_conv_pin_out_n(cn), .o_conv_pin_oe(coe), .o_ivl_pin_out(io),
      .o_ivl_pin_oe(ioe), .o_scan_clk(), .o_interval_mode(im), .o_sample_ctr_clk(), .o_ivl_ctr_clk());
   acq_far_side acq_far_side_i (.i_clk(i_clk), .i_fire(fire), .o_conv_n(fc), .o_clk(k));
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      starts <= starts + cs;
      lows <= lows + (coe && !cn);
      if (cyc == 1000) begin
         bad_count = bad_count + 1;
         print_verdict;
      end
   end
   task print_verdict; begin
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   end endtask
   task chk(input [7:0] e, input [7:0] g); begin
      n_checks = n_checks + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
   end endtask
   // write strobe held one cycle, then wait until the effect shows
   task wr_reg(input [7:0] a, input [7:0] d); begin
      @(posedge i_clk); #1 wr = 1; addr = a; wd = d;
      @(posedge i_clk); #1 wr = 0;
      repeat (2) @(posedge i_clk); #1;
   end endtask
   task pulse(input [7:0] e); begin
      s0 = starts; fire = 1;
      repeat (3) @(posedge i_clk); #1 fire = 0;
      repeat (4) @(posedge i_clk); #1 chk(e, 8'(starts - s0));
   end endtask
   initial begin
      repeat (20) @(posedge i_clk); #1 rst_n = 1;
      chk(8'h04, {4'h0, coe, ioe, mode});
      for (i = 0; i < 4; i = i + 1) begin
         ref_f = i[0];
         wr_reg(8'h0F, {4'h0, i[1], 3'h0});
         chk(i[1] ? 8'h02 : 8'(i[0]), {6'h0, mode});
      end
      wr_reg(8'h0E, 8'h1F);
      chk(8'h06, {4'h0, coe, ioe, mode});
      $display("test modes done");
      wr_reg(8'h0F, 8'h00);
      pulse(8'h01);
      wr_reg(8'h0F, 8'h10);
      pulse(8'h00);
      wr_reg(8'h0F, 8'h04);
      s0 = starts; l0 = lows; st = 1;
      @(posedge i_clk); #1 st = 0;
      repeat (14) @(posedge i_clk); #1 chk(8'h01, 8'(starts - s0));
      chk(8'h0A, 8'(lows - l0));
      $display("test convert done");
      tbs = 1;
      wr_reg(8'h0F, 8'h03);
      chk(8'h01, {6'h0, ioe, im});
      repeat (20) @(posedge i_clk); #1 wr_reg(8'h0F, 8'h00);
      chk(8'h02, {6'h0, ioe, im});
      repeat (20) @(posedge i_clk); #1 $display("test clocks done");
      print_verdict;
   end
endmodule
